// [src/tap_pkg.sv]
// constants, types and helpers of the sram boundary-scan test port
// assumes: tck side and system side are unrelated clocks
`default_nettype none

package tap_pkg;

  // ****************************************
  // sizes and codes
  // ****************************************
  localparam int IR_LEN = 3;
  localparam int ID_LEN = 32;
  localparam int BSR_LEN = 89;
  localparam int BALL_LEN = BSR_LEN - 1;

  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_IDCODE = 3'h1;
  localparam logic [2:0] INS_SAMPLEZ = 3'h2;
  localparam logic [2:0] INS_SAMPLE = 3'h4;
  localparam logic [2:0] INS_BYPASS = 3'h7;
  localparam logic [2:0] IR_CAPTURE = 3'h1;

  // ****************************************
  // id layout and preset values
  // ****************************************
  typedef struct packed {
    logic [2:0] rev;
    logic [16:0] dev;
    logic [10:0] ven;
    logic present;
  } id_s;

  localparam logic ID_PRESENT = 1'h1;
  localparam logic [BSR_LEN-1:0] BSR_PRESET = {1'h1, 88'h0};

  // ****************************************
  // controller states and tck-side state
  // ****************************************
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } tap_e;

  typedef struct packed {
    tap_e st;
    logic [IR_LEN-1:0] ir_sh;
    logic [IR_LEN-1:0] ir;
    logic byp;
    logic [ID_LEN-1:0] id_sh;
    logic [BSR_LEN-1:0] bsr;
    logic [BSR_LEN-1:0] upd;
    logic hiz;
  } tck_s;

  typedef struct packed {
    logic tdo;
    logic oe;
  } tdo_s;

  function automatic logic bsr_sel(input logic [2:0] ins);
    bsr_sel = (ins == INS_EXTEST) || (ins == INS_SAMPLEZ) || (ins == INS_SAMPLE);
  endfunction : bsr_sel

  function automatic logic hiz_sel(input logic [2:0] ins);
    hiz_sel = (ins == INS_EXTEST) || (ins == INS_SAMPLEZ);
  endfunction : hiz_sel

endpackage : tap_pkg

`default_nettype wire

// [src/level_sync.sv]
// two-flop synchroniser for levels, any width
// assumes: bits are independent levels; no word coherence is promised
`default_nettype none

module level_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RV = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;

  // first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_q <= RV;
      q <= RV;
    end
    else
    begin
      s1_q <= d;
      q <= s1_q;
    end
  end
endmodule : level_sync

`default_nettype wire

// [src/sram_tap.sv]
// boundary-scan test port of the sram, controller plus scan paths
// assumes: tck from the tester, pin ring values and output float on CLK
`default_nettype none

module sram_tap #(
  parameter logic [2:0] ID_REV = 3'h2,       // arbitrary value
  parameter logic [16:0] ID_DEV = 17'h12345, // arbitrary value
  parameter logic [10:0] ID_VEN = 11'h155,   // arbitrary value
  parameter logic [tap_pkg::BALL_LEN-1:0] NC_MASK = '0
) (
  // system side
  input wire logic CLK,
  input wire logic RST,
  input wire logic [tap_pkg::BALL_LEN-1:0] PIN_RING,
  output logic OUT_HIGHZ,
  // test port
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  output logic TDO,
  output logic TDO_OE
);
  import tap_pkg::*;

  // ****************************************
  // crossings
  // ****************************************
  logic rst_tck;
  logic [BALL_LEN-1:0] ring_tck;
  logic hiz_clk;
  logic out_hiz_q;
  tck_s q;
  tck_s d;
  tdo_s tq;
  id_s id_word;

  // reset reaches the tck side only while tck runs
  level_sync #(.W(1), .RV(1'h0)) u_rst_sync (
    .clk(TCK), .rst(1'h0), .d(RST), .q(rst_tck)
  );
  // ring may be mid-transition at capture; each bit settles alone
  level_sync #(.W(BALL_LEN), .RV('0)) u_ring_sync (
    .clk(TCK), .rst(rst_tck), .d(PIN_RING), .q(ring_tck)
  );
  level_sync #(.W(1), .RV(1'h0)) u_hiz_sync (
    .clk(CLK), .rst(RST), .d(q.hiz), .q(hiz_clk)
  );

  always_ff @(posedge CLK)
  begin
    if (RST)
      out_hiz_q <= 1'h0;
    else
      out_hiz_q <= hiz_clk;
  end

  assign OUT_HIGHZ = out_hiz_q;

  // ****************************************
  // controller and scan paths on rising tck
  // ****************************************
  assign id_word = '{rev: ID_REV, dev: ID_DEV, ven: ID_VEN, present: ID_PRESENT};

  function automatic tap_e tap_next(input tap_e s, input logic m);
    case (s)
      TLR: tap_next = m ? TLR : RTI;
      RTI: tap_next = m ? SEL_DR : RTI;
      SEL_DR: tap_next = m ? SEL_IR : CAP_DR;
      CAP_DR: tap_next = m ? EX1_DR : SH_DR;
      SH_DR: tap_next = m ? EX1_DR : SH_DR;
      EX1_DR: tap_next = m ? UPD_DR : PA_DR;
      PA_DR: tap_next = m ? EX2_DR : PA_DR;
      EX2_DR: tap_next = m ? UPD_DR : SH_DR;
      UPD_DR: tap_next = m ? SEL_DR : RTI;
      SEL_IR: tap_next = m ? TLR : CAP_IR;
      CAP_IR: tap_next = m ? EX1_IR : SH_IR;
      SH_IR: tap_next = m ? EX1_IR : SH_IR;
      EX1_IR: tap_next = m ? UPD_IR : PA_IR;
      PA_IR: tap_next = m ? EX2_IR : PA_IR;
      EX2_IR: tap_next = m ? UPD_IR : SH_IR;
      UPD_IR: tap_next = m ? SEL_DR : RTI;
      default: tap_next = TLR;
    endcase
  endfunction : tap_next

  always_comb
  begin
    d = q;
    d.st = tap_next(q.st, TMS);
    case (q.st)
      TLR:
      begin
        d.ir = INS_IDCODE;
        d.upd = BSR_PRESET;
      end
      CAP_IR: d.ir_sh = IR_CAPTURE;
      SH_IR: d.ir_sh = {TDI, q.ir_sh[IR_LEN-1:1]};
      UPD_IR: d.ir = q.ir_sh;
      CAP_DR:
      begin
        if (q.ir == INS_IDCODE)
          d.id_sh = id_word;
        else if (bsr_sel(q.ir))
          d.bsr = {q.upd[BSR_LEN-1], ring_tck & ~NC_MASK};
        else
          d.byp = 1'h0;
      end
      SH_DR:
      begin
        if (q.ir == INS_IDCODE)
          d.id_sh = {TDI, q.id_sh[ID_LEN-1:1]};
        else if (bsr_sel(q.ir))
          d.bsr = {TDI, q.bsr[BSR_LEN-1:1]};
        else
          d.byp = TDI;
      end
      UPD_DR:
      begin
        if (bsr_sel(q.ir))
          d.upd = q.bsr;
      end
      default:
      begin
      end
    endcase
    d.hiz = hiz_sel(q.ir);
    if (rst_tck)
    begin
      d.st = TLR;
      d.ir = INS_IDCODE;
      d.ir_sh = IR_CAPTURE;
      d.byp = 1'h0;
      d.id_sh = '0;
      d.bsr = BSR_PRESET;
      d.upd = BSR_PRESET;
      d.hiz = 1'h0;
    end
  end

  always_ff @(posedge TCK)
  begin
    q <= d;
  end

  // ****************************************
  // tdo on falling tck
  // ****************************************
  // separate falling-edge state so tdo holds through the rising edge
  always_ff @(negedge TCK)
  begin
    if (rst_tck)
      tq <= '0;
    else
    begin
      tq.oe <= (q.st == SH_IR) || (q.st == SH_DR);
      if (q.st == SH_IR)
        tq.tdo <= q.ir_sh[0];
      else if (q.ir == INS_IDCODE)
        tq.tdo <= q.id_sh[0];
      else if (bsr_sel(q.ir))
        tq.tdo <= q.bsr[0];
      else
        tq.tdo <= q.byp;
    end
  end

  assign TDO = tq.tdo;
  assign TDO_OE = tq.oe;

  // ****************************************
  // checks
  // ****************************************
  a_reset_seq: assert property (@(posedge TCK) disable iff (rst_tck) TMS [*5] |=> q.st == TLR)
    else $error("five tms highs did not reach reset state");
  a_tlr_idcode: assert property (@(posedge TCK) disable iff (rst_tck) q.st == TLR |=> q.ir == INS_IDCODE)
    else $error("reset state did not select id instruction");
  a_ir_update: assert property (@(posedge TCK) disable iff (rst_tck)
    $changed(q.ir) |-> $past(q.st) == UPD_IR || $past(q.st) == TLR)
    else $error("instruction changed outside update-ir");
  a_id_capture: assert property (@(posedge TCK) disable iff (rst_tck)
    q.st == CAP_DR && q.ir == INS_IDCODE |=> q.id_sh == {ID_REV, ID_DEV, ID_VEN, 1'h1})
    else $error("id word wrong after capture");
  // first id bit leaves on the falling edge right after shift-dr is entered
  a_id_lsb: assert property (@(posedge TCK) disable iff (rst_tck)
    q.st == CAP_DR && q.ir == INS_IDCODE ##1 q.st == SH_DR |-> TDO == 1'h1 && TDO_OE)
    else $error("first id bit out was not one");
  a_float_ir: assert property (@(posedge TCK) disable iff (rst_tck)
    q.st == UPD_IR ##1 hiz_sel(q.ir) |=> q.hiz)
    else $error("float request missing for extest or sample-z");
  a_keep_drive: assert property (@(posedge TCK) disable iff (rst_tck)
    q.ir == INS_SAMPLE || q.ir == INS_BYPASS || q.ir == INS_IDCODE |=> !q.hiz)
    else $error("outputs floated under a harmless instruction");
  a_ring_capture: assert property (@(posedge TCK) disable iff (rst_tck)
    q.st == CAP_DR && bsr_sel(q.ir) |=> q.bsr[BALL_LEN-1:0] == $past(ring_tck & ~NC_MASK))
    else $error("scan path did not take the ring snapshot");
  a_cell_last: assert property (@(posedge TCK) disable iff (rst_tck)
    q.st == CAP_DR && bsr_sel(q.ir) |=> q.bsr[BSR_LEN-1] == $past(q.upd[BSR_LEN-1]))
    else $error("internal cell did not capture its update value");
  // tdo carries the bypass bit taken at the latest rising edge
  a_bypass_out: assert property (@(posedge TCK) disable iff (rst_tck)
    q.st == SH_DR && q.ir == INS_BYPASS ##1 q.st == SH_DR |-> TDO == q.byp && TDO_OE)
    else $error("bypass bit not on tdo");
  a_oe_shift: assert property (@(posedge TCK) disable iff (rst_tck)
    q.st == SH_IR || q.st == SH_DR |-> TDO_OE)
    else $error("tdo not driven in a shift state");
  a_oe_idle: assert property (@(posedge TCK) disable iff (rst_tck)
    q.st != SH_IR && q.st != SH_DR |-> !TDO_OE)
    else $error("tdo driven outside shift states");
  a_cell_preset: assert property (@(posedge TCK) disable iff (rst_tck) q.st == TLR |=> q.upd == BSR_PRESET)
    else $error("scan cells not preset in reset state");
  a_float_cross: assert property (@(posedge CLK) disable iff (RST) $rose(hiz_clk) |=> OUT_HIGHZ)
    else $error("float request not passed to sram side");

  c_load_extest: cover property (@(posedge TCK) q.st == UPD_IR && q.ir_sh == INS_EXTEST);
  c_id_shift: cover property (@(posedge TCK) q.st == SH_DR && q.ir == INS_IDCODE);
  c_bypass_shift: cover property (@(posedge TCK) q.st == SH_DR && q.ir == INS_BYPASS);
  c_sample_upd: cover property (@(posedge TCK) q.st == UPD_DR && q.ir == INS_SAMPLE);
  c_float_on: cover property (@(posedge CLK) $rose(OUT_HIGHZ));

endmodule : sram_tap

`default_nettype wire

// [testbench/tap_tester.sv]
// test controller model: makes tck, drives tms and tdi, samples tdo
// assumes: the port updates tdo on falling tck and samples tms/tdi on rising tck
`default_nettype none

module tap_tester (
  // test port
  output var logic TCK,
  output var logic TMS,
  output var logic TDI,
  input wire logic TDO,
  input wire logic TDO_OE
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    TCK = 1'h0;
    TMS = 1'h1;
    TDI = 1'h0;
  end

  // one tck period; tck rests low between calls, so it stands still outside frames
  task automatic step(input logic tms_i, input logic tdi_i, output logic tdo_o, output logic oe_o);
    TMS = tms_i;
    TDI = tdi_i;
    #80;
    tdo_o = TDO;
    oe_o = TDO_OE;
    TCK = 1'h1;
    #80;
    TCK = 1'h0;
  endtask : step
endmodule : tap_tester

`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench of the sram boundary-scan test port
// assumes: tap_tester model on the test port, bench drives the system side
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import tap_pkg::*;
  // ****************************************
  // setup
  // ****************************************
  localparam logic [2:0] REV = 3'h5; // arbitrary value
  localparam logic [16:0] DEV = 17'h0ABCD; // arbitrary value
  localparam logic [10:0] VEN = 11'h2A6; // arbitrary value
  localparam logic [BALL_LEN-1:0] NC = 88'h20;
  localparam logic [BALL_LEN-1:0] RING = {22{4'hA}};
  logic clk, rst, out_highz, tck, tms, tdi, tdo, tdo_oe, bo, bd, oe_bad;
  logic [BALL_LEN-1:0] pin_ring;
  logic [BSR_LEN-1:0] got;
  int mismatches, total_checks;

  sram_tap #(.ID_REV(REV), .ID_DEV(DEV), .ID_VEN(VEN), .NC_MASK(NC)) dut (.CLK(clk), .RST(rst),
    .PIN_RING(pin_ring), .OUT_HIGHZ(out_highz), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe));
  tap_tester tst (.TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe));

  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [BSR_LEN-1:0] g, input logic [BSR_LEN-1:0] e, input string what);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask : chk

  task automatic final_report();
    if (mismatches == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  task automatic tm(input logic t);
    tst.step(t, 1'h0, bo, bd);
  endtask : tm

  // from run-test/idle through one shift and back to idle
  task automatic scan(input logic ir, input int n, input logic [BSR_LEN-1:0] din);
    tm(1'h1);
    if (ir)
      tm(1'h1);
    tm(1'h0);
    tm(1'h0);
    got = '0;
    oe_bad = 1'h0;
    for (int i = 0; i < n; i++)
    begin
      tst.step(i == n - 1, din[i], got[i], bd);
      oe_bad = oe_bad | (bd !== 1'h1);
    end
    tm(1'h1);
    tm(1'h0);
    chk(BSR_LEN'(oe_bad), '0, "tdo enable in shift");
    chk(BSR_LEN'(bd), '0, "tdo enable in update");
  endtask : scan

  task automatic ld(input logic [2:0] code);
    scan(1'h1, IR_LEN, BSR_LEN'(code));
    chk(got, BSR_LEN'(IR_CAPTURE), "instruction capture");
  endtask : ld

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_id();
    scan(1'h0, ID_LEN, '0);
    chk(got, BSR_LEN'({REV, DEV, VEN, 1'h1}), "id word");
  endtask : t_id

  task automatic t_bypass();
    ld(INS_BYPASS);
    scan(1'h0, 8, BSR_LEN'(8'hB5));
    chk(got, BSR_LEN'(8'h6A), "bypass delay");
  endtask : t_bypass

  // second pass shows the internal cell holding what the first pass updated
  task automatic t_sample();
    ld(INS_SAMPLE);
    scan(1'h0, BSR_LEN, '0);
    chk(got, {1'h1, RING & ~NC}, "first capture");
    @(negedge clk);
    pin_ring = ~RING;
    scan(1'h0, BSR_LEN, '0);
    chk(got, {1'h0, ~RING & ~NC}, "second capture");
  endtask : t_sample

  task automatic t_float();
    logic [2:0] codes [5] = '{INS_EXTEST, INS_SAMPLEZ, INS_SAMPLE, INS_BYPASS, INS_IDCODE};
    logic hz [5] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0};
    for (int k = 0; k < 5; k++)
    begin
      ld(codes[k]);
      tm(1'h0);
      repeat (6) @(negedge clk);
      chk(BSR_LEN'(out_highz), BSR_LEN'(hz[k]), "output float");
    end
    t_id();
  endtask : t_float

  task automatic t_tlr();
    ld(INS_BYPASS);
    repeat (5) tm(1'h1);
    tm(1'h0);
    t_id();
  endtask : t_tlr

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial
  begin
    mismatches = 0;
    total_checks = 0;
    rst = 1'h1;
    pin_ring = RING;
    // tck must run while reset is high so it reaches the tck side
    repeat (8) tm(1'h1);
    @(negedge clk);
    rst = 1'h0;
    repeat (3) tm(1'h1);
    tm(1'h0);
    chk(BSR_LEN'(out_highz), '0, "float after reset");
    t_id();
    t_bypass();
    t_sample();
    t_float();
    t_tlr();
    final_report();
  end

  initial
  begin
    #200us;
    mismatches++;
    final_report();
  end
endmodule : testbench

`default_nettype wire
